// [src/dst_pkg.sv]
// Purpose: Constants and types for the radio core deep-sleep timer.
// Assumes: One 10 MHz clock; the low-power and microsecond rates are enables.
// Notes:   Register offsets are full AHB byte addresses.
//
// How it works
// - External wake is ignored during sleep while the disable bit 31 is set.
// - Bit 15 reads one only while the core sits in deep sleep.
// - Writing one to bit 4 during sleep wakes the core; reads zero.
// - Writing one to bit 3 after wake restarts fine and slot counters.
// - Bit 2 requests sleep; hardware clears it when sleep ends.
// - Sleep lasts the programmed number of low-power cycles, then wakes.
// - A zero sleep length means sleep until a wake request arrives.
// - Elapsed counter clears at sleep start and counts low-power cycles.
// - After external wake the wake interrupt drops after bits 31:21 low-power cycles.
// - Wake interrupt rises bits 20:10 low-power cycles before expiry.
// - Wake interrupt falls bits 9:0 low-power cycles before expiry.
// - A 10-bit microsecond phase correction is held for the fine counter.
// - A 27-bit slot counter correction is held read-write.
// - The fine counter advances once per microsecond within each slot.

package dst_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [31:0] A_CTRL   = 32'h4000_0030;
    localparam logic [31:0] A_LENGTH = 32'h4000_0034;
    localparam logic [31:0] A_ELAPSE = 32'h4000_0038;
    localparam logic [31:0] A_TIMING = 32'h4000_003c;
    localparam logic [31:0] A_FINE   = 32'h4000_0040;
    localparam logic [31:0] A_SLOTC  = 32'h4000_0044;
    localparam logic [31:0] A_STATUS = 32'h4000_0048;
    localparam logic [31:0] A_MASK   = 32'h4000_004c;
    localparam logic [31:0] A_USCNT  = 32'h4000_0090;
    localparam logic [31:0] A_SLOTV  = 32'h4000_0094;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_EXT_DIS = 31;
    localparam int CTRL_STATE   = 15;
    localparam int CTRL_SW_WAKE = 4;
    localparam int CTRL_CORR    = 3;
    localparam int CTRL_SLEEP   = 2;
    localparam int IRQ_EN_HI    = 1;
    localparam int IRQ_EN_LO    = 0;
    localparam logic [1:0] IRQ_EN_ON = 2'h3;
    localparam int HOLD_HI = 31;
    localparam int HOLD_LO = 21;
    localparam int LEAD_HI = 20;
    localparam int LEAD_LO = 10;
    localparam int REL_HI  = 9;
    localparam int REL_LO  = 0;
    localparam int FINE_W  = 10;
    localparam int SLOT_W  = 27;
    localparam int HOLD_W  = 11;
    localparam logic [FINE_W-1:0] SLOT_US = 10'h271;

    // ------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------
    localparam int EV_SLEEP_DONE = 0;
    localparam int EV_WAKE_IRQ   = 1;
    localparam int EV_EXT_WAKE   = 2;
    localparam int EV_W          = 3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int US_PERIOD_NS  = 1000;
    localparam int LP_PERIOD_NS  = 30518;
    localparam int US_DIV        = US_PERIOD_NS / CLK_PERIOD_NS;
    localparam int LP_DIV        = LP_PERIOD_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_ACTIVE, ST_ENTER, ST_SLEEP} dst_state_t;

    typedef struct packed {
        logic [31:0] addr;
        logic        write;
        logic        valid;
    } dst_req_t;

endpackage

// [src/dst_sleep_timer.sv]
// Purpose: Deep-sleep timer with AHB-Lite registers and timebase correction.
// Assumes: All inputs are synchronous to hclk.
// Notes:   Every bus transfer takes one wait state.
//
// Chosen here: the AHB-Lite slave port.

`timescale 1ns/1ps

module dst_sleep_timer
    import dst_pkg::*;
#(
    parameter int LP_DIV_P = LP_DIV,
    parameter int US_DIV_P = US_DIV
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        ext_wake_req,
    output logic             lp_wake_interrupt,
    output logic             irq,
    output logic             sleep_state,
    output logic [FINE_W-1:0] us_counter_value,
    output logic [SLOT_W-1:0] slot_counter_value
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [EV_W-1:0] w1c(input logic [EV_W-1:0] cur,
                                            input logic [EV_W-1:0] set,
                                            input logic [EV_W-1:0] clr);
        w1c = (cur & ~clr) | set;
    endfunction

    function automatic logic [31:0] tick_count(input logic [31:0] cnt, input int div);
        if (cnt >= 32'(div - 1)) begin
            tick_count = 32'h0000_0000;
        end else begin
            tick_count = cnt + 32'h0000_0001;
        end
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    dst_req_t          req_ff;
    logic [31:0]       hrdata_ff;
    logic              hreadyout_ff;
    logic              hresp_ff;
    logic              ext_dis_ff;
    logic              sleep_req_ff;
    logic [1:0]        irq_en_ff;
    logic [31:0]       length_ff;
    logic [31:0]       elapsed_ff;
    logic [31:0]       rem_ff;
    logic [31:0]       timing_ff;
    logic [FINE_W-1:0] fine_adj_ff;
    logic [SLOT_W-1:0] slot_adj_ff;
    logic [EV_W-1:0]   status_ff;
    logic [EV_W-1:0]   mask_ff;
    dst_state_t        state_ff;
    logic              sleep_state_ff;
    logic              lp_irq_ff;
    logic              irq_ff;
    logic [HOLD_W-1:0] hold_ff;
    logic [31:0]       lp_div_ff;
    logic [31:0]       us_div_ff;
    logic              tb_run_ff;
    logic [FINE_W-1:0] fine_ff;
    logic [SLOT_W-1:0] slot_ff;
    logic              lp_tick;
    logic              us_tick;
    logic              wr_now;
    logic              rd_now;
    logic              sw_wake;
    logic              corr_go;
    logic              ext_wake;
    logic              expire;
    logic              wake_now;
    logic              nxt_lp_irq;
    logic [EV_W-1:0]   ev_set;
    logic [EV_W-1:0]   ev_clr;
    logic [31:0]       rd_word;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    assign wr_now  = req_ff.valid && req_ff.write;
    assign rd_now  = req_ff.valid && !req_ff.write;
    assign sw_wake = wr_now && (req_ff.addr == A_CTRL) && hwdata[CTRL_SW_WAKE];
    assign corr_go = wr_now && (req_ff.addr == A_CTRL) && hwdata[CTRL_CORR];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_ff       <= '0;
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
        end else if (req_ff.valid) begin
            req_ff       <= '0;
            hreadyout_ff <= 1'b1;
        end else if (hready && hsel && htrans[1]) begin
            req_ff.addr  <= haddr;
            req_ff.write <= hwrite;
            req_ff.valid <= 1'b1;
            hreadyout_ff <= 1'b0;
        end
    end

    always_comb begin
        rd_word = RST_WORD;
        case (req_ff.addr)
            A_CTRL: begin
                rd_word[CTRL_EXT_DIS]        = ext_dis_ff;
                rd_word[CTRL_STATE]          = sleep_state_ff;
                rd_word[CTRL_SLEEP]          = sleep_req_ff;
                rd_word[IRQ_EN_HI:IRQ_EN_LO] = irq_en_ff;
            end
            A_LENGTH: rd_word = length_ff;
            A_ELAPSE: rd_word = elapsed_ff;
            A_TIMING: rd_word = timing_ff;
            A_FINE:   rd_word[FINE_W-1:0] = fine_adj_ff;
            A_SLOTC:  rd_word[SLOT_W-1:0] = slot_adj_ff;
            A_STATUS: rd_word[EV_W-1:0] = status_ff;
            A_MASK:   rd_word[EV_W-1:0] = mask_ff;
            A_USCNT:  rd_word[FINE_W-1:0] = fine_ff;
            A_SLOTV:  rd_word[SLOT_W-1:0] = slot_ff;
            default:  rd_word = RST_WORD;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= RST_WORD;
        end else if (rd_now) begin
            hrdata_ff <= rd_word;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            length_ff   <= RST_WORD;
            timing_ff   <= RST_WORD;
            fine_adj_ff <= '0;
            slot_adj_ff <= '0;
            mask_ff     <= '0;
            ext_dis_ff  <= 1'b0;
            irq_en_ff   <= 2'h0;
        end else if (wr_now) begin
            case (req_ff.addr)
                A_CTRL: begin
                    ext_dis_ff <= hwdata[CTRL_EXT_DIS];
                    irq_en_ff  <= hwdata[IRQ_EN_HI:IRQ_EN_LO];
                end
                A_LENGTH: length_ff   <= hwdata;
                A_TIMING: timing_ff   <= hwdata;
                A_FINE:   fine_adj_ff <= hwdata[FINE_W-1:0];
                A_SLOTC:  slot_adj_ff <= hwdata[SLOT_W-1:0];
                A_MASK:   mask_ff     <= hwdata[EV_W-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Low-power and microsecond enables
    // ------------------------------------------------------------
    assign lp_tick = (lp_div_ff == 32'(LP_DIV_P - 1));
    assign us_tick = (us_div_ff == 32'(US_DIV_P - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lp_div_ff <= 32'h0000_0000;
            us_div_ff <= 32'h0000_0000;
        end else begin
            lp_div_ff <= tick_count(lp_div_ff, LP_DIV_P);
            us_div_ff <= tick_count(us_div_ff, US_DIV_P);
        end
    end

    // ------------------------------------------------------------
    // Sleep sequencer
    // ------------------------------------------------------------
    assign ext_wake = ext_wake_req && !ext_dis_ff && (state_ff == ST_SLEEP);
    assign expire   = lp_tick && (length_ff != 32'h0000_0000)
                      && (rem_ff == 32'h0000_0001);
    assign wake_now = (state_ff == ST_SLEEP) && (expire || sw_wake || ext_wake);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff       <= ST_ACTIVE;
            sleep_state_ff <= 1'b0;
            rem_ff         <= RST_WORD;
        end else begin
            case (state_ff)
                ST_ACTIVE: begin
                    if (sleep_req_ff) begin
                        state_ff <= ST_ENTER;
                    end
                end
                ST_ENTER: begin
                    if (!sleep_req_ff) begin
                        state_ff <= ST_ACTIVE;
                    end else if (lp_tick) begin
                        state_ff       <= ST_SLEEP;
                        sleep_state_ff <= 1'b1;
                        rem_ff         <= length_ff;
                    end
                end
                ST_SLEEP: begin
                    if (wake_now) begin
                        state_ff       <= ST_ACTIVE;
                        sleep_state_ff <= 1'b0;
                    end else if (lp_tick && rem_ff != 32'h0000_0000) begin
                        rem_ff <= rem_ff - 32'h0000_0001;
                    end
                end
                default: begin
                    state_ff       <= ST_ACTIVE;
                    sleep_state_ff <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_req_ff <= 1'b0;
        end else if (wake_now) begin
            sleep_req_ff <= 1'b0;
        end else if (wr_now && req_ff.addr == A_CTRL) begin
            sleep_req_ff <= hwdata[CTRL_SLEEP];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            elapsed_ff <= RST_WORD;
        end else if (state_ff == ST_ENTER && sleep_req_ff && lp_tick) begin
            elapsed_ff <= RST_WORD;
        end else if (state_ff == ST_SLEEP && lp_tick) begin
            elapsed_ff <= elapsed_ff + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // Low-power wake interrupt
    // ------------------------------------------------------------
    always_comb begin
        nxt_lp_irq = 1'b0;
        if (state_ff == ST_SLEEP && !wake_now) begin
            if (irq_en_ff == IRQ_EN_ON && length_ff != 32'h0000_0000) begin
                nxt_lp_irq = (rem_ff <= {21'h0, timing_ff[LEAD_HI:LEAD_LO]})
                          && (rem_ff > {22'h0, timing_ff[REL_HI:REL_LO]});
            end
        end else if (ext_wake) begin
            nxt_lp_irq = (timing_ff[HOLD_HI:HOLD_LO] != '0);
        end else begin
            nxt_lp_irq = lp_irq_ff && (hold_ff != '0);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_ff   <= '0;
            lp_irq_ff <= 1'b0;
        end else begin
            lp_irq_ff <= nxt_lp_irq;
            if (ext_wake) begin
                hold_ff <= timing_ff[HOLD_HI:HOLD_LO];
            end else if (lp_tick && hold_ff != '0) begin
                hold_ff <= hold_ff - 11'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    always_comb begin
        ev_set = '0;
        ev_clr = '0;
        ev_set[EV_SLEEP_DONE] = wake_now;
        ev_set[EV_WAKE_IRQ]   = nxt_lp_irq && !lp_irq_ff;
        ev_set[EV_EXT_WAKE]   = ext_wake;
        if (wr_now && req_ff.addr == A_STATUS) begin
            ev_clr = hwdata[EV_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_ff <= '0;
            irq_ff    <= 1'b0;
        end else begin
            status_ff <= w1c(status_ff, ev_set, ev_clr);
            irq_ff    <= |(w1c(status_ff, ev_set, ev_clr) & mask_ff);
        end
    end

    // ------------------------------------------------------------
    // Timebase counters
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tb_run_ff <= 1'b1;
            fine_ff   <= '0;
            slot_ff   <= '0;
        end else if (corr_go && state_ff == ST_ACTIVE) begin
            fine_ff   <= fine_adj_ff;
            slot_ff   <= slot_adj_ff;
            tb_run_ff <= 1'b1;
        end else if (state_ff == ST_SLEEP) begin
            tb_run_ff <= 1'b0;
        end else if (tb_run_ff && us_tick) begin
            if (fine_ff >= SLOT_US - 10'h001) begin
                fine_ff <= '0;
                slot_ff <= slot_ff + 27'h000_0001;
            end else begin
                fine_ff <= fine_ff + 10'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata             = hrdata_ff;
    assign hreadyout          = hreadyout_ff;
    assign hresp              = hresp_ff;
    assign lp_wake_interrupt  = lp_irq_ff;
    assign irq                = irq_ff;
    assign sleep_state        = sleep_state_ff;
    assign us_counter_value   = fine_ff;
    assign slot_counter_value = slot_ff;

endmodule

// [test/dst_sleep_timer_sva.sv]
// Purpose: Concurrent checks on the deep-sleep timer ports.
// Assumes: One clock; hready is tied to hreadyout.
// Notes:   Helper logic tracks bus transfers and two written fields.

`timescale 1ns/1ps

module dst_sleep_timer_sva
    import dst_pkg::*;
#(
    parameter int LP_DIV_P = LP_DIV,
    parameter int US_DIV_P = US_DIV
) (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [2:0]        hsize,
    input wire logic [31:0]       hwdata,
    input wire logic              hready,
    input wire logic [31:0]       hrdata,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire logic              ext_wake_req,
    input wire logic              lp_wake_interrupt,
    input wire logic              irq,
    input wire logic              sleep_state,
    input wire logic [FINE_W-1:0] us_counter_value,
    input wire logic [SLOT_W-1:0] slot_counter_value
);
    // ----------------------------------------------------------------
    // Transfer tracking
    // ----------------------------------------------------------------
    logic        pend_ff;
    logic        wr_ff;
    logic [31:0] addr_ff;
    logic        dis_ff;
    logic [10:0] hold_ff;
    logic        done;
    logic        rd_done;
    logic        mapped;

    assign done    = pend_ff && hreadyout;
    assign rd_done = done && !wr_ff;
    assign mapped  = addr_ff inside {A_CTRL, A_LENGTH, A_ELAPSE, A_TIMING, A_FINE,
                                     A_SLOTC, A_STATUS, A_MASK, A_USCNT, A_SLOTV};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_ff <= 1'b0;
            wr_ff   <= 1'b0;
            addr_ff <= 32'h0;
        end else if (hsel && hready && htrans[1]) begin
            pend_ff <= 1'b1;
            wr_ff   <= hwrite;
            addr_ff <= haddr;
        end else if (hreadyout) begin
            pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dis_ff  <= 1'b0;
            hold_ff <= 11'h0;
        end else if (done && wr_ff) begin
            if (addr_ff == A_CTRL) begin
                dis_ff <= hwdata[CTRL_EXT_DIS];
            end
            if (addr_ff == A_TIMING) begin
                hold_ff <= hwdata[HOLD_HI:HOLD_LO];
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_resp_always_okay: assert property (hresp == 1'b0)
        else $error("hresp not OKAY");
    a_one_wait_state: assert property ((hsel && hready && htrans[1])
        |=> !hreadyout ##1 hreadyout) else $error("wait state not one cycle");
    a_ctrl_write_only: assert property (rd_done && addr_ff == A_CTRL
        |-> hrdata[4:3] == 2'h0 && hrdata[30:16] == 15'h0 && hrdata[14:5] == 10'h0)
        else $error("control read shows write-only or reserved bits");
    a_state_flag_read: assert property (rd_done && addr_ff == A_CTRL
        |-> hrdata[CTRL_STATE] == $past(sleep_state)) else $error("sleep flag read wrong");
    a_unmapped_reads_zero: assert property (rd_done && !mapped |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_us_in_slot: assert property (us_counter_value < SLOT_US)
        else $error("fine counter beyond slot");
    a_us_wrap_slot: assert property ((us_counter_value == SLOT_US - 10'h1)
        ##1 (us_counter_value == 10'h0)
        |-> slot_counter_value == $past(slot_counter_value) + 27'h1)
        else $error("slot counter did not step on wrap");
    a_ext_wake_ends: assert property (sleep_state && ext_wake_req && !dis_ff
        |-> ##[1:2] !sleep_state) else $error("external wake ignored");
    a_ext_irq_rises: assert property (sleep_state && ext_wake_req && !dis_ff
        && hold_ff != 11'h0 |-> ##[1:2] lp_wake_interrupt)
        else $error("wake interrupt missing on external wake");
endmodule

bind dst_sleep_timer dst_sleep_timer_sva #(.LP_DIV_P(LP_DIV_P), .US_DIV_P(US_DIV_P)) u_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_wake_req(ext_wake_req),
    .lp_wake_interrupt(lp_wake_interrupt), .irq(irq), .sleep_state(sleep_state),
    .us_counter_value(us_counter_value), .slot_counter_value(slot_counter_value));

// [test/dst_sleep_timer_bench.sv]
// Purpose: Register-level tests of the deep-sleep timer.
// Assumes: Short dividers; one slave, so hready is hreadyout.
// Notes:   All inputs but hclk change by non-blocking assignment after a rising edge.

`timescale 1ns/1ps

module dst_sleep_timer_bench;
    import dst_pkg::*;
    localparam int LPD = 4;
    localparam int USD = 2;

    logic              hclk = 1'b0;
    logic              hresetn = 1'b0;
    logic              hsel = 1'b0;
    logic [31:0]       haddr = 32'h0;
    logic [1:0]        htrans = 2'h0;
    logic              hwrite = 1'b0;
    logic [2:0]        hsize = 3'h2;
    logic [31:0]       hwdata = 32'h0;
    logic              ext_wake_req = 1'b0;
    logic [31:0]       hrdata;
    logic              hreadyout;
    logic              hresp;
    logic              lp_wake_interrupt;
    logic              irq;
    logic              sleep_state;
    logic [FINE_W-1:0] us_counter_value;
    logic [SLOT_W-1:0] slot_counter_value;
    logic [31:0]       rd;
    int                miscompares = 0;
    int                n_compared = 0;
    int                lp_n;
    localparam logic [31:0] RA [6] = '{A_LENGTH, A_ELAPSE, A_TIMING, A_FINE, A_SLOTC, A_MASK};
    localparam logic [31:0] RM [6] = '{32'hffffffff, 32'h0, 32'hffffffff, 32'h3ff,
                                       32'h7ffffff, 32'h7};

    always #50 hclk = ~hclk;

    dst_sleep_timer #(.LP_DIV_P(LPD), .US_DIV_P(USD)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ext_wake_req(ext_wake_req), .lp_wake_interrupt(lp_wake_interrupt), .irq(irq),
        .sleep_state(sleep_state), .us_counter_value(us_counter_value),
        .slot_counter_value(slot_counter_value));

    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task automatic ahb_xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_rd(input string name, input logic [31:0] a, input logic [31:0] exp);
        ahb_xfer(1'b0, a, 32'h0);
        check32(name, exp, rd);
    endtask

    task automatic check_range(input string name, input logic [31:0] lo, input logic [31:0] hi,
                               input logic [31:0] got);
        n_compared++;
        if (((got >= lo) && (got <= hi)) !== 1'b1) begin
            miscompares++;
            $display("wrong value %s expected %h..%h seen %h", name, lo, hi, got);
        end
    endtask

    task automatic wait_state(input logic v);
        int i;
        i = 0;
        while (sleep_state !== v && i < 400) begin
            @(posedge hclk);
            i++;
        end
        check32("sleep_state", {31'h0, v}, {31'h0, sleep_state});
    endtask

    task automatic print_verdict();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #(100 * 30000);
        miscompares++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check_rd("ctrl_reset", A_CTRL, RST_WORD);
        check_rd("status_reset", A_STATUS, RST_WORD);
        for (int k = 0; k < 6; k++) begin
            check_rd("reg_reset", RA[k], RST_WORD);
            ahb_xfer(1'b1, RA[k], 32'hffffffff);
            check_rd("reg_access", RA[k], RM[k]);
        end
        ahb_xfer(1'b1, 32'h4000_0050, 32'hffffffff);
        check_rd("unmapped", 32'h4000_0050, 32'h0);
        ahb_xfer(1'b1, A_CTRL, 32'h8000_0010);
        check_rd("ctrl_rw", A_CTRL, 32'h8000_0000);
        $display("test registers done");

        ahb_xfer(1'b1, A_TIMING, {11'h2, 11'h3, 10'h1});
        ahb_xfer(1'b1, A_LENGTH, 32'h8);
        ahb_xfer(1'b1, A_CTRL, 32'h7);
        wait_state(1'b1);
        lp_n = 0;
        for (int i = 0; i < 400 && sleep_state === 1'b1; i++) begin
            @(posedge hclk);
            if (lp_wake_interrupt === 1'b1) lp_n++;
        end
        check32("lp_irq_cycles", (3 - 1) * LPD, lp_n);
        wait_state(1'b0);
        check_rd("elapsed", A_ELAPSE, 32'h8);
        check_rd("ctrl_after", A_CTRL, 32'h3);
        check_rd("status_timed", A_STATUS, 32'h3);
        check32("irq_on", 32'h1, {31'h0, irq});
        ahb_xfer(1'b1, A_MASK, 32'h0);
        repeat (2) @(posedge hclk);
        check32("irq_masked", 32'h0, {31'h0, irq});
        ahb_xfer(1'b1, A_MASK, 32'h7);
        ahb_xfer(1'b1, A_STATUS, 32'h3);
        repeat (2) @(posedge hclk);
        check32("irq_cleared", 32'h0, {31'h0, irq});
        check_rd("status_clr", A_STATUS, 32'h0);
        $display("test timed sleep done");

        ahb_xfer(1'b1, A_LENGTH, 32'h0);
        ahb_xfer(1'b1, A_CTRL, 32'h8000_0007);
        wait_state(1'b1);
        ext_wake_req <= 1'b1;
        repeat (60) @(posedge hclk);
        check32("sleep_held", 32'h1, {31'h0, sleep_state});
        check_rd("ctrl_asleep", A_CTRL, 32'h8000_8007);
        ext_wake_req <= 1'b0;
        ahb_xfer(1'b1, A_CTRL, 32'h0000_0017);
        wait_state(1'b0);
        check32("no_lp_sw", 32'h0, {31'h0, lp_wake_interrupt});
        ahb_xfer(1'b1, A_CTRL, 32'h7);
        wait_state(1'b1);
        ext_wake_req <= 1'b1;
        wait_state(1'b0);
        ext_wake_req <= 1'b0;
        check32("lp_ext_on", 32'h1, {31'h0, lp_wake_interrupt});
        repeat (4 * LPD) @(posedge hclk);
        check32("lp_ext_off", 32'h0, {31'h0, lp_wake_interrupt});
        check_rd("status_ext", A_STATUS, 32'h7);
        $display("test wake requests done");

        ahb_xfer(1'b1, A_FINE, 32'h100);
        ahb_xfer(1'b1, A_SLOTC, 32'h55);
        ahb_xfer(1'b1, A_CTRL, 32'h8);
        check_rd("fine_adj", A_FINE, 32'h100);
        ahb_xfer(1'b0, A_USCNT, 32'h0);
        check_range("us_loaded", 32'h100, 32'h106, rd);
        check_rd("slot_loaded", A_SLOTV, 32'h55);
        ahb_xfer(1'b1, A_FINE, 32'h26f);
        ahb_xfer(1'b1, A_CTRL, 32'h8);
        repeat (20) @(posedge hclk);
        check32("slot_step", 32'h56, {5'h0, slot_counter_value});
        check_range("us_wrapped", 32'h0, 32'hf, {22'h0, us_counter_value});
        $display("test correction done");
        print_verdict();
    end
endmodule
